// [core/rtcsb_cfg.svh]
`ifndef RTCSB_CFG_SVH
`define RTCSB_CFG_SVH

// ----------------------------------------
// Bus addressing
// ----------------------------------------
`define RTCSB_SLAVE_ADDR 8'hD0
`define RTCSB_PTR_W 3
`define RTCSB_NUM_REGS 8

// ----------------------------------------
// Register indices, in pointer order
// ----------------------------------------
`define RTCSB_SECONDS_COUNT 3'h0
`define RTCSB_MINUTES_COUNT 3'h1
`define RTCSB_CENTURY_HOURS_COUNT 3'h2
`define RTCSB_WEEKDAY_COUNT 3'h3
`define RTCSB_DAY_OF_MONTH_COUNT 3'h4
`define RTCSB_MONTH_COUNT 3'h5
`define RTCSB_YEARS_COUNT 3'h6
`define RTCSB_CALIBRATION_CONTROL 3'h7

// ----------------------------------------
// Reset values and bit counts
// ----------------------------------------
`define RTCSB_REG_RST 8'h00
`define RTCSB_PTR_RST 3'h0
`define RTCSB_BYTE_BITS 4'h8
`define RTCSB_LAST_BIT 4'h7

`endif

// [core/rtcsb_pkg.sv]
`include "rtcsb_cfg.svh"

package rtcsb_pkg;

	// ----------------------------------------
	// Link state machine
	// ----------------------------------------
	typedef enum logic [6:0] {
		LK_IDLE = 7'h01,
		LK_ADDR = 7'h02,
		LK_AACK = 7'h04,
		LK_RX = 7'h08,
		LK_RACK = 7'h10,
		LK_TX = 7'h20,
		LK_MACK = 7'h40
	} rtcsb_lk_state_t;

	// ----------------------------------------
	// Link domain state
	// ----------------------------------------
	typedef struct packed {
		rtcsb_lk_state_t st;
		logic scl_m;
		logic scl_s;
		logic scl_d;
		logic sda_m;
		logic sda_s;
		logic sda_d;
		logic pf_m;
		logic pf_s;
		logic [7:0] shift;
		logic [7:0] tx;
		logic [3:0] cnt;
		logic rw;
		logic first;
		logic macked;
		logic sda_oe;
		logic sda_lo;
		logic [`RTCSB_PTR_W-1:0] ptr;
		logic req_tgl;
		logic req_wr;
		logic [`RTCSB_PTR_W-1:0] req_addr;
		logic [7:0] req_data;
		logic [7:0] rdata;
		logic ack_m;
		logic ack_s;
		logic ack_d;
	} rtcsb_lk_t;

	// ----------------------------------------
	// Register domain state
	// ----------------------------------------
	typedef struct packed {
		logic [`RTCSB_NUM_REGS-1:0][7:0] regs;
		logic [7:0] rdata;
		logic tgl_m;
		logic tgl_s;
		logic tgl_d;
		logic ack_tgl;
	} rtcsb_core_t;

endpackage

// [core/rtcsb_slave.sv]
// Summary of operation
// - Respond only to START followed by the fixed slave address.
// - Eight bytes in order: seconds to years, then control.
// - Clock and calendar bytes are held as BCD values as written.
// - Pointer advances automatically after each written data byte and after each read byte the master acknowledges.
// - Power fail aborts the transfer and clears the pointer.
// - While power fails, bus inputs are ignored; resume when supply returns.
// - Both lines high means the bus is free.
// - START is data falling while clock is high.
// - STOP is data rising while clock is high; it ends the transfer.
// - Data change with clock high is a control condition, not data.
// - One clock pulse per bit; data changes only with clock low.
// - Transfers open with START, close with STOP; any byte count.
// - Eight-bit bytes, each followed by a ninth acknowledge bit.
// - When addressed and receiving, acknowledge every byte by pulling data low.
// - Acknowledge holds data low through the whole ninth clock high.
// - After a withheld acknowledge, release the data line for STOP.
// - Pointer advances only when an acknowledge is given or received.
// - Random read: word address write, repeated START, then read.
// - Read without word address starts at the current pointer.
// - Write: first byte loads pointer, later bytes stored then pointer advances.

`include "rtcsb_cfg.svh"

module rtcsb_slave #(
	parameter logic [7:0] SLAVE_ADDR = `RTCSB_SLAVE_ADDR
) (
	// Register clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link sampling clock
	input wire logic link_clk_i,
	// Serial bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Supply monitor
	input wire logic pwr_fail_i,
	// Register contents
	output logic [8*`RTCSB_NUM_REGS-1:0] regs_o
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [`RTCSB_PTR_W-1:0] next_ptr(input logic [`RTCSB_PTR_W-1:0] p);
		if (p == `RTCSB_CALIBRATION_CONTROL) begin
			next_ptr = `RTCSB_SECONDS_COUNT;
		end else begin
			next_ptr = p + `RTCSB_PTR_W'(1);
		end
	endfunction

	rtcsb_pkg::rtcsb_lk_t l_reg;
	rtcsb_pkg::rtcsb_lk_t l_next;
	rtcsb_pkg::rtcsb_core_t c_reg;
	rtcsb_pkg::rtcsb_core_t c_next;

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	always_comb begin
		logic scl_rise;
		logic scl_fall;
		logic start_det;
		logic stop_det;
		scl_rise = 1'b0;
		scl_fall = 1'b0;
		start_det = 1'b0;
		stop_det = 1'b0;
		l_next = l_reg;
		l_next.sda_lo = 1'b0;
		l_next.scl_m = scl_i;
		l_next.scl_s = l_reg.scl_m;
		l_next.scl_d = l_reg.scl_s;
		l_next.sda_m = sda_i;
		l_next.sda_s = l_reg.sda_m;
		l_next.sda_d = l_reg.sda_s;
		l_next.pf_m = pwr_fail_i;
		l_next.pf_s = l_reg.pf_m;
		l_next.ack_m = c_reg.ack_tgl;
		l_next.ack_s = l_reg.ack_m;
		l_next.ack_d = l_reg.ack_s;
		// Catch read data answered by the register side
		if (l_reg.ack_s != l_reg.ack_d) begin
			l_next.rdata = c_reg.rdata;
		end
		// sample on rise, drive on fall
		scl_rise = l_reg.scl_s & ~l_reg.scl_d;
		scl_fall = ~l_reg.scl_s & l_reg.scl_d;
		start_det = l_reg.scl_s & l_reg.scl_d & l_reg.sda_d & ~l_reg.sda_s;
		stop_det = l_reg.scl_s & l_reg.scl_d & ~l_reg.sda_d & l_reg.sda_s;
		if (l_reg.pf_s) begin
			l_next.st = rtcsb_pkg::LK_IDLE;
			l_next.sda_oe = 1'b0;
			l_next.macked = 1'b0;
			l_next.ptr = `RTCSB_PTR_RST;
		end else if (start_det) begin
			l_next.st = rtcsb_pkg::LK_ADDR;
			l_next.cnt = 4'h0;
			l_next.shift = 8'h00;
			l_next.sda_oe = 1'b0;
			l_next.macked = 1'b0;
		end else if (stop_det) begin
			l_next.st = rtcsb_pkg::LK_IDLE;
			l_next.sda_oe = 1'b0;
			l_next.macked = 1'b0;
		end else begin
			case (l_reg.st)
				rtcsb_pkg::LK_IDLE: begin
					l_next.sda_oe = 1'b0;
				end
				rtcsb_pkg::LK_ADDR: begin
					if (scl_rise) begin
						l_next.shift = {l_reg.shift[6:0], l_reg.sda_s};
						l_next.cnt = l_reg.cnt + 4'h1;
					end else if (scl_fall && l_reg.cnt == `RTCSB_BYTE_BITS) begin
						if (l_reg.shift[7:1] == SLAVE_ADDR[7:1]) begin
							l_next.sda_oe = 1'b1;
							l_next.rw = l_reg.shift[0];
							l_next.first = ~l_reg.shift[0];
							l_next.st = rtcsb_pkg::LK_AACK;
							if (l_reg.shift[0]) begin
								l_next.req_tgl = ~l_reg.req_tgl;
								l_next.req_wr = 1'b0;
								l_next.req_addr = l_reg.ptr;
							end
						end else begin
							l_next.st = rtcsb_pkg::LK_IDLE;
						end
					end
				end
				rtcsb_pkg::LK_AACK: begin
					if (scl_fall) begin
						l_next.cnt = 4'h0;
						l_next.shift = 8'h00;
						if (l_reg.rw) begin
							l_next.tx = l_reg.rdata;
							l_next.sda_oe = ~l_reg.rdata[7];
							l_next.st = rtcsb_pkg::LK_TX;
						end else begin
							l_next.sda_oe = 1'b0;
							l_next.st = rtcsb_pkg::LK_RX;
						end
					end
				end
				rtcsb_pkg::LK_RX: begin
					if (scl_rise) begin
						l_next.shift = {l_reg.shift[6:0], l_reg.sda_s};
						l_next.cnt = l_reg.cnt + 4'h1;
					end else if (scl_fall && l_reg.cnt == `RTCSB_BYTE_BITS) begin
						l_next.sda_oe = 1'b1;
						l_next.st = rtcsb_pkg::LK_RACK;
						l_next.first = 1'b0;
						if (l_reg.first) begin
							l_next.ptr = l_reg.shift[`RTCSB_PTR_W-1:0];
						end else begin
							l_next.req_tgl = ~l_reg.req_tgl;
							l_next.req_wr = 1'b1;
							l_next.req_addr = l_reg.ptr;
							l_next.req_data = l_reg.shift;
							l_next.ptr = next_ptr(l_reg.ptr);
						end
					end
				end
				rtcsb_pkg::LK_RACK: begin
					if (scl_fall) begin
						l_next.sda_oe = 1'b0;
						l_next.cnt = 4'h0;
						l_next.shift = 8'h00;
						l_next.st = rtcsb_pkg::LK_RX;
					end
				end
				rtcsb_pkg::LK_TX: begin
					if (scl_fall) begin
						if (l_reg.cnt == `RTCSB_LAST_BIT) begin
							l_next.sda_oe = 1'b0;
							l_next.st = rtcsb_pkg::LK_MACK;
						end else begin
							l_next.cnt = l_reg.cnt + 4'h1;
							l_next.tx = {l_reg.tx[6:0], 1'b0};
							l_next.sda_oe = ~l_reg.tx[6];
						end
					end
				end
				rtcsb_pkg::LK_MACK: begin
					if (scl_rise) begin
						if (!l_reg.sda_s) begin
							l_next.macked = 1'b1;
							l_next.ptr = next_ptr(l_reg.ptr);
							l_next.req_tgl = ~l_reg.req_tgl;
							l_next.req_wr = 1'b0;
							l_next.req_addr = next_ptr(l_reg.ptr);
						end else begin
							l_next.sda_oe = 1'b0;
							l_next.st = rtcsb_pkg::LK_IDLE;
						end
					end else if (scl_fall && l_reg.macked) begin
						l_next.macked = 1'b0;
						l_next.cnt = 4'h0;
						l_next.tx = l_reg.rdata;
						l_next.sda_oe = ~l_reg.rdata[7];
						l_next.st = rtcsb_pkg::LK_TX;
					end
				end
				default: begin
					l_next.st = rtcsb_pkg::LK_IDLE;
					l_next.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			l_reg <= '0;
			l_reg.st <= rtcsb_pkg::LK_IDLE;
			l_reg.scl_m <= 1'b1;
			l_reg.scl_s <= 1'b1;
			l_reg.scl_d <= 1'b1;
			l_reg.sda_m <= 1'b1;
			l_reg.sda_s <= 1'b1;
			l_reg.sda_d <= 1'b1;
		end else begin
			l_reg <= l_next;
		end
	end

	// ----------------------------------------
	// Register domain
	// ----------------------------------------
	always_comb begin
		c_next = c_reg;
		c_next.tgl_m = l_reg.req_tgl;
		c_next.tgl_s = c_reg.tgl_m;
		c_next.tgl_d = c_reg.tgl_s;
		if (c_reg.tgl_s != c_reg.tgl_d) begin
			if (l_reg.req_wr) begin
				c_next.regs[l_reg.req_addr] = l_reg.req_data;
			end
			c_next.rdata = c_reg.regs[l_reg.req_addr];
			c_next.ack_tgl = ~c_reg.ack_tgl;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			c_reg <= '0;
			c_reg.regs <= {`RTCSB_NUM_REGS{`RTCSB_REG_RST}};
		end else begin
			c_reg <= c_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign sda_o = l_reg.sda_lo;
	assign sda_oe_o = l_reg.sda_oe;
	assign regs_o = c_reg.regs;

endmodule // rtcsb_slave

// [bench/rtcsb_chk.sv]
`include "rtcsb_cfg.svh"

module rtcsb_chk (
	// Clocks and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	// Bus and supply
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic pwr_fail_i,
	// Register image
	input wire logic [8*`RTCSB_NUM_REGS-1:0] regs_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// Bus conditions
	// ----------------------------------------
	default clocking cb @(posedge link_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_start;
		$fell(sda_i) && scl_i && $past(scl_i);
	endsequence
	sequence s_stop;
		$rose(sda_i) && scl_i && $past(scl_i);
	endsequence
	drive_low_a: assert property (sda_oe_o |-> sda_o == 1'b0)
		else $error("data drive not low");
	pf_quiet_a: assert property (pwr_fail_i [*6] |-> !sda_oe_o)
		else $error("drive during power fail");
	pf_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pwr_fail_i && $past(pwr_fail_i, 8) |-> $stable(regs_o)) else $error("write in power fail");
	edge_safe_a: assert property ($changed(sda_oe_o) && !pwr_fail_i
		&& !$past(pwr_fail_i, 4) |-> !scl_i) else $error("drive change with clock high");
	data_hold_a: assert property ($rose(scl_i) && !pwr_fail_i |-> $stable(sda_oe_o) [*4])
		else $error("drive moved in clock high");
	stop_quiet_a: assert property (s_stop |-> (!sda_oe_o) [*6])
		else $error("drive after stop");
	start_quiet_a: assert property (s_start |-> (!sda_oe_o) [*6])
		else $error("drive after start");
	reset_clear_a: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |-> regs_o == '0 && !sda_oe_o) else $error("reset not clear");
	cover property (s_start);
	cover property ($rose(sda_oe_o));
	cover property (@(posedge clk_i) $changed(regs_o));
endmodule // rtcsb_chk

bind rtcsb_slave rtcsb_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
	.scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.pwr_fail_i(pwr_fail_i), .regs_o(regs_o));

// [bench/rtcsb_master.sv]
module rtcsb_master (
	// Clock and bus
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl_o = 1'b1;
		sda_oe_o = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
		#2;
	endtask
	task automatic start;
		sda_oe_o = 1'b0;
		w(30);
		scl_o = 1'b1;
		w(30);
		sda_oe_o = 1'b1;
		w(30);
		scl_o = 1'b0;
		w(8);
	endtask
	task automatic stop;
		sda_oe_o = 1'b1;
		w(30);
		scl_o = 1'b1;
		w(30);
		sda_oe_o = 1'b0;
		w(30);
	endtask
	// set in low, held in high
	task automatic bit_x(input logic b, output logic r);
		sda_oe_o = !b;
		w(30);
		scl_o = 1'b1;
		w(30);
		r = sda_i;
		scl_o = 1'b0;
		w(8);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
		output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(ak, a);
	endtask
endmodule // rtcsb_master

// [bench/rtc_serial_bus_slave_bench.sv]
module rtc_serial_bus_slave_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] ad; logic [7:0] dt;} rtcsb_row_t;
	localparam rtcsb_row_t ROWS [8] = '{'{8'h00, 8'h59}, '{8'h01, 8'h59}, '{8'h02, 8'h23},
		'{8'h03, 8'h07}, '{8'h04, 8'h31}, '{8'h05, 8'h12}, '{8'h06, 8'h99}, '{8'h07, 8'h80}};
	logic clk_i = 1'b0, link_clk_i = 1'b0, rst_i = 1'b1, pwr_fail_i = 1'b0;
	logic scl, m_oe, dut_sda, dut_oe, a;
	logic [7:0] q;
	logic [63:0] regs;
	logic [7:0] mem [8] = '{default: 8'h00};
	int err_count = 0, cmp_count = 0;
	wire sda = !m_oe && (!dut_oe || dut_sda);
	initial forever #25 clk_i = ~clk_i;
	initial begin
		#13;
		forever #62.5 link_clk_i = ~link_clk_i;
	end
	rtcsb_slave dut_u (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .scl_i(scl),
		.sda_i(sda), .sda_o(dut_sda), .sda_oe_o(dut_oe), .pwr_fail_i(pwr_fail_i), .regs_o(regs));
	rtcsb_master m_u (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
	// ----------------------------------------
	// Checks and bus helpers
	// ----------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_ack(input logic got, input logic exp);
		chk({63'h0, got}, {63'h0, exp});
	endtask
	function automatic logic [63:0] img;
		for (int i = 0; i < 8; i++) img[8*i +: 8] = mem[i];
	endfunction
	task automatic wr(input logic [7:0] b, input logic ea);
		m_u.xfer(b, 1'b1, q, a);
		chk_ack(a, ea);
	endtask
	task automatic rd(input logic nak, input logic [7:0] e);
		m_u.xfer(8'hFF, nak, q, a);
		chk({56'h0, q}, {56'h0, e});
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		wrap_up;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		#2;
		rst_i = 1'b0;
		chk(regs, 64'h0);
		foreach (ROWS[i]) begin
			m_u.start();
			wr(8'hD0, 1'b0);
			wr(ROWS[i].ad, 1'b0);
			wr(ROWS[i].dt, 1'b0);
			mem[i] = ROWS[i].dt;
			chk(regs, img());
			m_u.start();
			wr(8'hD0, 1'b0);
			wr(ROWS[i].ad, 1'b0);
			m_u.start();
			wr(8'hD1, 1'b0);
			rd(1'b1, ROWS[i].dt);
			m_u.stop();
		end
		m_u.start();
		wr(8'hD0, 1'b0);
		wr(8'h06, 1'b0);
		wr(8'hA1, 1'b0);
		wr(8'hA2, 1'b0);
		wr(8'hA3, 1'b0);
		m_u.stop();
		mem[6] = 8'hA1;
		mem[7] = 8'hA2;
		mem[0] = 8'hA3;
		chk(regs, img());
		m_u.start();
		wr(8'hD1, 1'b0);
		rd(1'b0, mem[1]);
		rd(1'b0, mem[2]);
		rd(1'b1, mem[3]);
		repeat (16) @(posedge clk_i);
		chk_ack(dut_oe, 1'b0);
		m_u.stop();
		m_u.start();
		wr(8'hD1, 1'b0);
		rd(1'b1, mem[3]);
		m_u.start();
		wr(8'hD2, 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h55, 1'b1);
		m_u.stop();
		chk(regs, img());
		m_u.start();
		wr(8'hD0, 1'b0);
		wr(8'h05, 1'b0);
		pwr_fail_i = 1'b1;
		wr(8'h77, 1'b1);
		m_u.stop();
		chk(regs, img());
		pwr_fail_i = 1'b0;
		repeat (40) @(posedge clk_i);
		m_u.start();
		wr(8'hD1, 1'b0);
		rd(1'b1, mem[0]);
		m_u.stop();
		rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		#2;
		chk(regs, 64'h0);
		rst_i = 1'b0;
		wrap_up;
	end
endmodule // rtc_serial_bus_slave_bench
